// *** rtl/sdp_regs.svh ***
// Purpose: offsets, field positions and reset values of the data port
// Assumes: included by its bare name from design files
// Notes:   byte addresses on the register bus, 32-bit words
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH

`define SDP_CTRL_OFS   4'h0
`define SDP_STAT_OFS   4'h4
`define SDP_CTRL_RST   32'h0000_0000
`define SDP_CTRL_HOLD  0
`define SDP_STAT_MODE  0
`define SDP_STAT_SEL   1
`define SDP_STAT_DROP  2
`define SDP_STAT_LVL   4
`define SDP_LANES      4
`define SDP_BYTE_W     8

`endif

// *** rtl/sdp_pkg.sv ***
// Purpose: shared types of the data port
// Assumes: nothing
// Notes:   constants live in sdp_regs.svh
package sdp_pkg;

  typedef enum logic {
    SDP_BUS_IDLE,
    SDP_BUS_ACK
  } sdp_bus_st_t;

  typedef enum logic {
    SDP_BURST_LINEAR,
    SDP_BURST_INTERLEAVED
  } sdp_burst_t;

endpackage : sdp_pkg

// *** rtl/sdp_stream_if.sv ***
// Purpose: valid/ready word stream between data port modules
// Assumes: one clock, owned by the modules on either side
// Notes:   a word moves on an edge where valid and ready are both high
`timescale 1ns/1ps
interface sdp_stream_if #(
  parameter int W = 8
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sdp_stream_if

// *** rtl/sdp_pair_buf.sv ***
// Purpose: small FIFO holding captured write words until the array takes them
// Assumes: run low freezes every register
// Notes:   ready on the filling side is honest: low only when full
`timescale 1ns/1ps
module sdp_pair_buf
  import sdp_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 2,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  // Clock and control
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             run,
  // Streams
  sdp_stream_if.snk             in_s,
  sdp_stream_if.src             out_s,
  // Fill level
  output      logic [LVL_W-1:0] level
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]     slot_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [LVL_W-1:0] cnt_q;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : ptr_inc

  wire push = run && in_s.valid && in_s.ready;
  wire pop  = run && out_s.valid && out_s.ready;

  assign in_s.ready  = (cnt_q != LVL_W'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = slot_q[rd_ptr_q];
  assign level       = cnt_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) wr_ptr_q <= ptr_inc(wr_ptr_q);
      if (pop)  rd_ptr_q <= ptr_inc(rd_ptr_q);
      if (push && !pop) cnt_q <= cnt_q + LVL_W'(1);
      if (pop && !push) cnt_q <= cnt_q - LVL_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) slot_q[wr_ptr_q] <= in_s.data;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  buf_bound_a: assert property (cnt_q <= LVL_W'(DEPTH))
    else $error("buffer level above depth");
  buf_order_a: assert property (push && cnt_q == '0 && !pop |=>
                                out_s.valid && out_s.data == $past(in_s.data))
    else $error("word pushed into empty buffer not at head");
endmodule : sdp_pair_buf

// *** rtl/sdp_data_port.sv ***
// Purpose: data and parity path of a flow-through burst SRAM, with burst
//          order strap and a small register window
// Assumes: all pins except out_gate_n and burst_mode are synchronous to
//          core_clk; the controller holds burst_mode static
// Notes:   clock_gate_n high freezes everything except the output gate
//          path, so the pins still float when the gate is raised
//
// Summary of operation
// [R01] Data pins are captured into the write path on a rising edge.
// [R02] A read drives the word addressed at the previous rising edge.
// [R03] Data and parity drive only while the output gate is low; the code keeps driving until the third rising edge after the gate rises.
// [R04] Pins float in write data phase, first selected clock, and deselect.
// [R05] Parity lines behave exactly like data lines.
// [R06] Each parity bit is stored only with its own byte select.
// [R07] Strap low picks linear bursts; high or open picks interleaved.
// [R08] Controller pulls write strobe low at a live edge to start writes.
// [R09] Byte selects are active low, sampled, and need the write strobe.
// [R10] Clock gate high ignores edges and keeps the current selection.
// [R11] Burst order is static configuration, not changed mid-access.
`timescale 1ns/1ps
`include "sdp_regs.svh"
module sdp_data_port
  import sdp_pkg::*;
#(
  parameter int ADDR_W    = 19,
  parameter int BUF_DEPTH = 2
) (
  // Clock, reset and clock gate
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clock_gate_n,
  // Access control pins
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              adv_ld_n,
  input  wire logic              write_n,
  input  wire logic [3:0]        byte_write_select_n,
  input  wire logic              chip_select_a_n,
  input  wire logic              chip_select_b,
  input  wire logic              chip_select_c_n,
  input  wire logic              out_gate_n,
  input  wire logic              burst_mode,
  // Data and parity pins
  input  wire logic [31:0]       dq_in,
  output      logic [31:0]       dq_out,
  output      logic              dq_oe,
  input  wire logic [3:0]        parity_lines_in,
  output      logic [3:0]        parity_lines_out,
  output      logic              parity_lines_oe,
  // Write path back-pressure
  output      logic              write_ready,
  // Register bus
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output      logic [31:0]       avs_readdata,
  output      logic              avs_waitrequest
);
  localparam int WORD_W = 36;
  localparam int PKT_W  = ADDR_W + 4 + WORD_W;
  localparam int LVL_W  = $clog2(BUF_DEPTH + 1);

  logic [WORD_W-1:0] mem [2**ADDR_W];

  logic              gate_s1_q;
  logic              gate_s2_q;
  logic              mode_s1_q;
  logic              mode_s2_q;
  logic              prev_sel_q;
  logic [ADDR_W-1:0] base_q;
  logic [1:0]        cnt_q;
  logic              wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [3:0]        wr_be_q;
  logic [WORD_W-1:0] rd_q;
  logic              drive_q;
  logic              oe_q;
  logic              wready_q;
  logic [31:0]       ctrl_q;
  logic              drop_q;
  sdp_bus_st_t       bus_st_q;
  logic              wait_q;
  logic [31:0]       rdata_q;
  logic [31:0]       stat_word;
  logic [LVL_W-1:0]  buf_lvl;

  sdp_stream_if #(.W(PKT_W)) push_s ();
  sdp_stream_if #(.W(PKT_W)) pop_s ();

  function automatic logic [ADDR_W-1:0] burst_addr(
    input logic [ADDR_W-1:0] base,
    input logic [1:0]        step,
    input logic              il
  );
    logic [1:0] lo;
    lo = il ? (base[1:0] ^ step) : (base[1:0] + step);
    return {base[ADDR_W-1:2], lo};
  endfunction : burst_addr

  function automatic logic [WORD_W-1:0] lane_mask(input logic [3:0] be);
    logic [WORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < `SDP_LANES; i++) begin
      m[i*`SDP_BYTE_W +: `SDP_BYTE_W] = {`SDP_BYTE_W{be[i]}};
      m[32 + i] = be[i];
    end
    return m;
  endfunction : lane_mask

  // Decode of the sampled control pins
  wire              run      = !clock_gate_n; // [R10]
  wire              mode_il  = (mode_s2_q == 1'b1); // [R07] [R11]
  wire              sel_now  = !chip_select_a_n && chip_select_b
                               && !chip_select_c_n;
  wire              wr_now   = sel_now && !write_n; // [R08] [R09]
  wire              rd_now   = sel_now && write_n;
  wire [ADDR_W-1:0] eff_addr = adv_ld_n ?
                               burst_addr(base_q, cnt_q + 2'h1, mode_il) :
                               addr; // [R07]
  wire [WORD_W-1:0] mem_word = mem[eff_addr];
  // Floats on writes, deselect and the first clock after deselect
  wire              drive_d  = run ? (rd_now && prev_sel_q) : drive_q; // [R04]

  // Write path: data phase is the cycle after the write command
  assign push_s.valid = run && wr_pend_q;
  assign push_s.data  = {wr_addr_q, wr_be_q, parity_lines_in, dq_in}; // [R01] [R05]
  wire              push_drop = push_s.valid && !push_s.ready;

  wire [ADDR_W-1:0] pop_addr = pop_s.data[PKT_W-1 -: ADDR_W];
  wire [3:0]        pop_be   = pop_s.data[WORD_W +: 4];
  wire [WORD_W-1:0] pop_word = pop_s.data[WORD_W-1:0];
  wire [WORD_W-1:0] pop_mask = lane_mask(pop_be);
  wire [WORD_W-1:0] pop_old  = mem[pop_addr];
  wire              pop_fire = run && pop_s.valid && pop_s.ready;
  // Software hold stalls the drain so the buffer really fills
  assign pop_s.ready = !ctrl_q[`SDP_CTRL_HOLD];

  // Register bus decode
  wire bus_req  = avs_read || avs_write;
  wire hit_ctrl = (avs_address == `SDP_CTRL_OFS);
  wire hit_stat = (avs_address == `SDP_STAT_OFS);
  wire wr_take  = (bus_st_q == SDP_BUS_ACK) && avs_write && avs_byteenable[0];
  wire drop_clr = wr_take && hit_stat && avs_writedata[`SDP_STAT_DROP];
  wire [31:0] rd_val = hit_ctrl ? ctrl_q : (hit_stat ? stat_word : 32'h0);

  always_comb begin
    stat_word = '0;
    stat_word[`SDP_STAT_MODE] = mode_il;
    stat_word[`SDP_STAT_SEL]  = prev_sel_q;
    stat_word[`SDP_STAT_DROP] = drop_q;
    stat_word[`SDP_STAT_LVL +: LVL_W] = buf_lvl;
  end

  sdp_pair_buf #(
    .W     (PKT_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (run),
    .in_s     (push_s),
    .out_s    (pop_s),
    .level    (buf_lvl)
  );

  // Async pins: gate runs free so the pins float even while frozen
  always_ff @(posedge core_clk) begin
    gate_s1_q <= out_gate_n;
    gate_s2_q <= gate_s1_q;
    oe_q      <= drive_d && !gate_s2_q; // [R03] [R05]
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_s1_q <= 1'b1;
      mode_s2_q <= 1'b1;
    end else if (run) begin
      mode_s1_q <= burst_mode;
      mode_s2_q <= mode_s1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prev_sel_q <= 1'b0;
      base_q     <= '0;
      cnt_q      <= '0;
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= '0;
      wr_be_q    <= '0;
      drive_q    <= 1'b0;
    end else if (run) begin
      prev_sel_q <= sel_now;
      drive_q    <= drive_d;
      wr_pend_q  <= wr_now;
      wr_addr_q  <= eff_addr;
      wr_be_q    <= ~byte_write_select_n; // [R09]
      if (sel_now) begin
        base_q <= adv_ld_n ? base_q : addr;
        cnt_q  <= adv_ld_n ? cnt_q + 2'h1 : 2'h0;
      end
    end
  end

  // Flow-through read: word leaves the array at the command edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_q <= '0;
    end else if (run && rd_now) begin
      rd_q <= mem_word; // [R02] [R05]
    end
  end

  always_ff @(posedge core_clk) begin
    if (pop_fire) begin
      mem[pop_addr] <= (pop_old & ~pop_mask) | (pop_word & pop_mask); // [R06]
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wready_q <= 1'b1;
      drop_q   <= 1'b0;
      ctrl_q   <= `SDP_CTRL_RST;
      bus_st_q <= SDP_BUS_IDLE;
      wait_q   <= 1'b1;
      rdata_q  <= '0;
    end else if (run) begin
      wready_q <= push_s.ready;
      // A drop in the clearing cycle stays recorded
      drop_q   <= push_drop || (drop_q && !drop_clr);
      if (wr_take && hit_ctrl) ctrl_q[7:0] <= avs_writedata[7:0];
      unique case (bus_st_q)
        SDP_BUS_IDLE: begin
          if (bus_req) begin
            bus_st_q <= SDP_BUS_ACK;
            wait_q   <= 1'b0;
            rdata_q  <= rd_val;
          end
        end
        SDP_BUS_ACK: begin
          bus_st_q <= SDP_BUS_IDLE;
          wait_q   <= 1'b1;
        end
      endcase
    end
  end

  assign dq_out           = rd_q[31:0];
  assign parity_lines_out = rd_q[35:32];
  assign dq_oe            = oe_q;
  assign parity_lines_oe  = oe_q;
  assign write_ready      = wready_q;
  assign avs_readdata     = rdata_q;
  assign avs_waitrequest  = wait_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_write_cmd;
    run && wr_now ##1 run;
  endsequence
  sequence s_load_adv;
    run && sel_now && !adv_ld_n ##1 run && sel_now && adv_ld_n;
  endsequence

  wr_capture_a: assert property ( // [R01]
    s_write_cmd ##0 (buf_lvl == '0) |=>
      pop_s.valid && pop_word == $past({parity_lines_in, dq_in}))
    else $error("write data not captured in data phase");
  rd_flow_a: assert property ( // [R02]
    run && rd_now |=> {parity_lines_out, dq_out} == $past(mem_word))
    else $error("read word is not the addressed location");
  gate_float_a: assert property ( // [R03]
    gate_s2_q |=> !dq_oe && !parity_lines_oe)
    else $error("pins driven while output gate high");
  write_float_a: assert property ( // [R04]
    run && wr_now |=> !dq_oe && !parity_lines_oe)
    else $error("pins driven in write data phase");
  emerge_float_a: assert property ( // [R04]
    run && !sel_now ##1 run && sel_now |=> !dq_oe)
    else $error("pins driven on first clock after deselect");
  parity_same_a: assert property ( // [R05]
    run && rd_now && prev_sel_q && !gate_s2_q |=>
      parity_lines_oe && dq_oe && parity_lines_out == $past(mem_word[35:32]))
    else $error("parity lines not steered like data");
  lane_store_a: assert property ( // [R06]
    pop_fire |=> (mem[$past(pop_addr)][35:32] & ~$past(pop_be))
                 == ($past(pop_old[35:32]) & ~$past(pop_be)))
    else $error("parity stored without its byte select");
  burst_order_a: assert property ( // [R07]
    s_load_adv |-> (mode_il ? eff_addr[1:0] == ($past(addr[1:0]) ^ 2'h1)
                            : eff_addr[1:0] == $past(addr[1:0]) + 2'h1))
    else $error("burst step does not follow the strap");
  strobe_qual_a: assert property ( // [R09]
    run && sel_now && write_n |=> !push_s.valid)
    else $error("write captured without write strobe");
  freeze_hold_a: assert property ( // [R10]
    !run |=> $stable(rd_q) && $stable(prev_sel_q) && $stable(ctrl_q))
    else $error("state changed while clock gated");
  bus_answer_a: assert property (
    run && bus_st_q == SDP_BUS_IDLE && bus_req ##1 run |-> !avs_waitrequest)
    else $error("register bus answer late");
endmodule : sdp_data_port

// *** testbench/sdp_ctrl_model.sv ***
// Purpose: memory controller model driving the data port pins
// Assumes: each cyc call launches one command just after a rising edge
// Notes:   released data lines show the inverse of the last word driven
`timescale 1ns/1ps
module sdp_ctrl_model #(
  parameter int AW = 6
) (
  // Clock
  input  wire logic          core_clk,
  // Memory outputs
  input  wire logic [31:0]   dq_out,
  input  wire logic [3:0]    parity_lines_out,
  input  wire logic          dq_oe,
  // Command pins
  output      logic [AW-1:0] addr = '0,
  output      logic          adv_ld_n = 1'h0,
  output      logic          write_n = 1'h1,
  output      logic [3:0]    byte_write_select_n = 4'hf,
  output      logic          chip_select_a_n = 1'h1,
  output      logic          chip_select_b = 1'h0,
  output      logic          chip_select_c_n = 1'h1,
  // Data pins
  output      logic [31:0]   dq_in,
  output      logic [3:0]    parity_lines_in
);
  logic [35:0] drv_q = '0;
  logic [35:0] last_q = '0;
  logic        drv_en_q = 1'h0;

  // A floating bus must not look like the last word written
  assign {parity_lines_in, dq_in} = drv_en_q ? drv_q :
                                    dq_oe ? {parity_lines_out, dq_out} :
                                    ~last_q;

  task automatic cyc(input logic sel, input logic wr, input logic adv,
                     input logic [AW-1:0] a, input logic [3:0] bws,
                     input logic dv, input logic [35:0] d);
    @(posedge core_clk);
    chip_select_a_n     <= !sel;
    chip_select_b       <= sel;
    chip_select_c_n     <= !sel;
    write_n             <= !wr;
    adv_ld_n            <= adv;
    addr                <= a;
    byte_write_select_n <= bws;
    drv_en_q            <= dv;
    drv_q               <= d;
    if (drv_en_q) begin
      last_q <= drv_q;
    end
  endtask : cyc
endmodule : sdp_ctrl_model

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the data port
// Assumes: address width reduced to 6; the controller model drives pins
// Notes:   pin reads are judged 1 ns after the edge that samples them
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      n_fail++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench;
  logic        core_clk = 1'h0, reset = 1'h1, clock_gate_n = 1'h0;
  logic        out_gate_n = 1'h0, burst_mode = 1'h1;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
  logic        avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, dq_in, dq_out;
  logic        avs_waitrequest, dq_oe, parity_lines_oe, write_ready;
  logic [5:0]  addr;
  logic        adv_ld_n, write_n, chip_select_a_n, chip_select_b;
  logic        chip_select_c_n;
  logic [3:0]  byte_write_select_n, parity_lines_in, parity_lines_out;
  logic [35:0] mem [64];
  int          n_fail = 0, samples_checked = 0;

  always #4 core_clk = ~core_clk;

  sdp_data_port #(.ADDR_W(6), .BUF_DEPTH(2)) sdp_data_port_inst (
    .core_clk, .reset, .clock_gate_n, .addr, .adv_ld_n, .write_n,
    .byte_write_select_n, .chip_select_a_n, .chip_select_b,
    .chip_select_c_n, .out_gate_n, .burst_mode, .dq_in, .dq_out, .dq_oe,
    .parity_lines_in, .parity_lines_out, .parity_lines_oe, .write_ready,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);

  sdp_ctrl_model #(.AW(6)) sdp_ctrl_model_inst (
    .core_clk, .dq_out, .parity_lines_out, .dq_oe, .addr, .adv_ld_n,
    .write_n, .byte_write_select_n, .chip_select_a_n, .chip_select_b,
    .chip_select_c_n, .dq_in, .parity_lines_in);

  function automatic logic [35:0] pat(input logic [5:0] a,
                                      input logic [7:0] s);
    return {a[3:0] ^ s[3:0], {2'h3, a, 2'h2, a, 2'h1, a, 2'h0, a} ^ {4{s}}};
  endfunction : pat

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] be,
                    output logic [31:0] q);
    @(posedge core_clk);
    avs_address    <= a;
    avs_read       <= !w;
    avs_write      <= w;
    avs_writedata  <= d;
    avs_byteenable <= be;
    // Request stands until an edge samples waitrequest low
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask : av

  task automatic rd(input logic [5:0] a);
    sdp_ctrl_model_inst.cyc(1'h1, 1'h0, 1'h0, a, 4'hf, 1'h0, 36'h0);
  endtask : rd

  task automatic idle();
    sdp_ctrl_model_inst.cyc(1'h0, 1'h0, 1'h0, 6'h0, 4'hf, 1'h0, 36'h0);
  endtask : idle

  // Data cycle is deselected, so the next read is a first selected clock
  task automatic wr(input logic [5:0] a, input logic [3:0] bws,
                    input logic [35:0] d);
    sdp_ctrl_model_inst.cyc(1'h1, 1'h1, 1'h0, a, bws, 1'h0, 36'h0);
    sdp_ctrl_model_inst.cyc(1'h0, 1'h0, 1'h0, a, 4'hf, 1'h1, d);
    for (int i = 0; i < 4; i++) begin
      if (!bws[i]) begin
        mem[a][8*i +: 8] = d[8*i +: 8];
        mem[a][32+i] = d[32+i];
      end
    end
  endtask : wr

  task automatic look(input logic [35:0] ex, input logic oe);
    #1;
    `CHK("read_word", ex, {parity_lines_out, dq_out})
    `CHK("data_oe", oe, dq_oe)
    `CHK("parity_oe", oe, parity_lines_oe)
  endtask : look

  task automatic t_rw();
    for (int i = 8; i < 12; i++) wr(6'(i), 4'h0, pat(6'(i), 8'h0));
    idle();
    idle();
    rd(6'h8);
    for (int i = 9; i < 12; i++) begin
      rd(6'(i));
      look(mem[i-1], i != 9);
    end
    idle();
    look(mem[11], 1'h1);
    idle();
    #1;
    `CHK("desel_oe", 1'h0, dq_oe)
  endtask : t_rw

  task automatic t_lanes();
    wr(6'h9, 4'ha, pat(6'h9, 8'hff));
    sdp_ctrl_model_inst.cyc(1'h1, 1'h0, 1'h0, 6'ha, 4'h0, 1'h0, 36'h0);
    idle();
    idle();
    rd(6'h9);
    rd(6'ha);
    look(mem[9], 1'h0);
    idle();
    look(mem[10], 1'h1);
  endtask : t_lanes

  task automatic t_gate();
    @(posedge core_clk);
    out_gate_n <= 1'h1;
    repeat (5) rd(6'h8);
    #1;
    `CHK("gated_oe", 1'h0, dq_oe)
    `CHK("gated_par_oe", 1'h0, parity_lines_oe)
    @(posedge core_clk);
    out_gate_n <= 1'h0;
    repeat (5) rd(6'h8);
    look(mem[8], 1'h1);
  endtask : t_gate

  task automatic t_cg();
    rd(6'ha);
    @(posedge core_clk);
    clock_gate_n <= 1'h1;
    rd(6'hb);
    rd(6'hb);
    look(mem[10], 1'h1);
    @(posedge core_clk);
    clock_gate_n <= 1'h0;
    idle();
    look(mem[11], 1'h1);
  endtask : t_cg

  task automatic t_burst();
    logic [31:0] q;
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      burst_mode <= m[0];
      repeat (4) idle();
      av(1'h0, 4'h4, 32'h0, 4'hf, q);
      `CHK("mode_bit", m[0], q[0])
      rd(6'h9);
      for (int k = 1; k < 5; k++) begin
        sdp_ctrl_model_inst.cyc(k < 4, 1'h0, 1'h1, 6'h9, 4'hf, 1'h0, 36'h0);
        look(mem[m ? (9 ^ (k - 1)) : (8 + k % 4)], k != 1);
      end
    end
  endtask : t_burst

  task automatic t_regs();
    logic [31:0] q;
    logic [35:0] old;
    av(1'h0, 4'h0, 32'h0, 4'hf, q);
    `CHK("ctrl_reset", 32'h0, q)
    av(1'h0, 4'h8, 32'h0, 4'hf, q);
    `CHK("unmapped", 32'h0, q)
    av(1'h1, 4'h0, 32'h1, 4'he, q);
    av(1'h0, 4'h0, 32'h0, 4'hf, q);
    `CHK("ctrl_no_be", 32'h0, q)
    wr(6'he, 4'h0, pat(6'he, 8'h0));
    av(1'h1, 4'h0, 32'h1, 4'hf, q);
    wr(6'hc, 4'h0, pat(6'hc, 8'h5a));
    wr(6'hd, 4'h0, pat(6'hd, 8'h5a));
    old = mem[14];
    wr(6'he, 4'h0, pat(6'he, 8'h5a));
    mem[14] = old;
    idle();
    #1;
    `CHK("buf_full", 1'h0, write_ready)
    av(1'h0, 4'h4, 32'h0, 4'hf, q);
    `CHK("status_full", 32'h25, q)
    av(1'h1, 4'h0, 32'h0, 4'hf, q);
    av(1'h1, 4'h4, 32'h4, 4'hf, q);
    av(1'h0, 4'h4, 32'h0, 4'hf, q);
    `CHK("status_empty", 32'h1, q)
    `CHK("buf_ready", 1'h1, write_ready)
    rd(6'hc);
    rd(6'hd);
    look(mem[12], 1'h0);
    rd(6'he);
    look(mem[13], 1'h1);
    idle();
    look(mem[14], 1'h1);
  endtask : t_regs

  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    t_rw();
    t_lanes();
    t_gate();
    t_cg();
    t_burst();
    t_regs();
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    complete_run();
  end
endmodule : testbench
